// ### ccr_top.sv
// Codec clock, reset, sync and control register housekeeping
// Function
// R01 - Host supplies system clock at 256, 384 or 512 times sample rate.
// R02 - Detect clock ratio and divide 384 and 512 down to 256.
// R03 - Sense crystal_in clock; buffer it out, else take sysclk pin input. The code leaves sysclk_pin_in unused.
// R04 - Power-on initialization completes in 1024 system clock cycles.
// R05 - Host holds reset_n_pin low at least 40 ns with clock running.
// R06 - Initialization starts at reset_n_pin rise and lasts 1024 cycles.
// R07 - Host keeps frame clock synchronous to system clock, any phase.
// R08 - Drift over 6 bit clocks: DAC held at bipolar zero until resync.
// R09 - Same loss: ADC outputs bipolar-zero codes until resync.
// R10 - Drift of 5 or fewer bit clocks: operation stays normal.
// R11 - Software mode takes control data over three-wire port.
// R12 - Pin-programmed variant only offers data format selection.
// R13 - Four 16-bit program registers selected by two select bits.
// R14 - Bits 10 and 9 select registers zero to three.
// R15 - Host writes zero to all reserved bits.
// R16 - Register zero: bit 8 left commit, bits 7-0 left gain.
// R17 - Register one: bit 8 right commit, bits 7-0 right gain.
// R18 - Register two holds sleep, hpf skip, COMMON_ATTENUATION_SELECT, zero detect, hold, de-emph, mute.
// R19 - Register three holds loopback, frame format, lr polarity.
// R20 - Reset defaults: format 0, all features off, gain 0 dB.
// R21 - Gains wait for a commit bit, then both channels apply together.
// R22 - Gain code 00h mutes, FFh is 0 dB.
// R23 - Zero detect cuts DAC output after 65,536 zero bit clocks.
// R24 - Common attenuation uses register zero gain for both channels.
// R25 - 16 bits MSB first on shift clock rise; applied on latch rise.
// R26 - Ratio found by counting clocks per frame against 256, 384, 512.
module ccr_top
  import ccr_pkg::*;
#(
  parameter int unsigned ZERO_RUN_LEN = ZERO_RUN_BITS, // Zero run in bit clocks
  parameter int unsigned INIT_LEN     = INIT_CYCLES    // Init length in cycles
) (
  input  wire logic       clk,                  // System clock, 20 MHz
  input  wire logic       srst,                 // Synchronous reset
  input  wire logic       ce,                   // Clock enable
  input  wire logic       software_mode,        // High: serial control port used
  input  wire logic       reset_n_pin,          // External reset, active low
  input  wire logic       crystal_in,           // Oscillator input level
  input  wire logic       sysclk_pin_in,        // sysclk_pin_bidir input side
  input  wire logic       sample_frame_clock,   // Frame clock level
  input  wire logic       serial_bit_clock,     // Bit clock level
  input  wire logic       dac_data_zero,        // DAC input bit is zero
  input  wire logic       control_shift_clock,  // Control port clock
  input  wire logic       control_serial_data,  // Control port data
  input  wire logic       control_latch_strobe, // Control port latch
  input  wire logic [2:0] format_pins,          // Format straps in pin mode
  output logic            sysclk_pin_out,       // sysclk_pin_bidir output
  output logic            sysclk_pin_oe,        // sysclk_pin_bidir enable
  output logic            core_clk_en,          // Enable giving 256x rate
  output logic            init_busy,            // Initialization running
  output logic            sync_lost,            // Frame sync lost
  output logic            dac_force_bpz,        // DAC forced to bipolar zero
  output logic            adc_force_bpz,        // ADC codes forced to zero
  output logic            dac_disconnect,       // Zero run detected
  output logic      [1:0] ratio_code,           // Detected clock ratio
  output ccr_pkg::ccr_cfg_t cfg                 // Settings in force
);
  import ccr_pkg::*;

  localparam int unsigned XTAL_WIN = 64; // Cycles to see a crystal edge

  typedef struct packed {
    logic        rst_pin_d;
    logic        xtal_d;
    logic [6:0]  xtal_cnt;
    logic        xtal_live;
    logic        sysclk_out;
    logic        sysclk_oe;
    ccr_seq_t    seq;
    logic [10:0] init_cnt;
    logic        frame_d;
    logic        bck_d;
    logic        rise_d;
    logic [9:0]  ref_period;
    logic        ref_valid;
    logic        lost;
    logic [16:0] zero_cnt;
    logic        disc;
    logic [1:0]  div_cnt;
    logic        clk_en;
    ccr_cfg_t    cfg;
    logic        busy;
    logic        dac_bpz;
    logic        adc_bpz;
    logic [7:0]  right_out;
  } ccr_top_state_t;

  ccr_top_state_t st_reg;
  ccr_top_state_t st_next;
  ccr_word_t      word;
  logic [1:0]     ratio_sel;
  logic           ratio_ok;
  logic [9:0]     period;
  logic           frame_rise;
  logic [9:0]     drift;
  logic [9:0]     bck_len;
  logic [9:0]     lost_lim;

  assign frame_rise = sample_frame_clock && !st_reg.frame_d;

  // Serial control port, three wires; see R11
  ccr_serial_port u_port (
    .clk       (clk),
    .srst      (srst),
    .ce        (ce),
    .shift_clk (control_shift_clock),
    .ser_data  (control_serial_data),
    .latch_stb (control_latch_strobe),
    .word_out  (word)
  );

  // Ratio measurement
  ccr_ratio_detect u_ratio (
    .clk        (clk),
    .srst       (srst),
    .ce         (ce),
    .frame_rise (frame_rise),
    .ratio_sel  (ratio_sel),
    .ratio_ok   (ratio_ok),
    .period     (period)
  );

  // Phase drift against the previous frame's period, in system clocks
  assign drift = (period > st_reg.ref_period) ? period - st_reg.ref_period
                                              : st_reg.ref_period - period;

  // One bit clock in system clocks, taking 64 bit clocks to a frame
  assign bck_len  = (ratio_sel == 2'h2) ? (RATIO_512 >> 3'h6)
                  : ((ratio_sel == 2'h1) ? (RATIO_384 >> 3'h6) : (RATIO_256 >> 3'h6));
  assign lost_lim = 10'(SYNC_LOSS_BITS) * bck_len;

  // Main next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.rst_pin_d = reset_n_pin;
    st_next.xtal_d    = crystal_in;
    st_next.frame_d   = sample_frame_clock;
    st_next.bck_d     = serial_bit_clock;

    // Crystal activity: any edge in the window keeps it live
    if (crystal_in != st_reg.xtal_d) begin
      st_next.xtal_cnt  = '0;
      st_next.xtal_live = 1'b1; // see R03
    end else if (st_reg.xtal_cnt == 7'(XTAL_WIN)) begin
      st_next.xtal_live = 1'b0; // see R03
    end else begin
      st_next.xtal_cnt = st_reg.xtal_cnt + 7'h01;
    end
    st_next.sysclk_oe  = st_reg.xtal_live; // see R03
    st_next.sysclk_out = st_reg.xtal_live ? crystal_in : 1'b0;

    // Initialization sequence, restarted by pin release
    case (st_reg.seq)
      CCR_INIT: begin
        st_next.init_cnt = st_reg.init_cnt + 11'h001;
        if (st_reg.init_cnt == 11'(INIT_LEN - 1)) begin
          st_next.seq = CCR_RUN; // see R04 see R06
        end
      end
      CCR_RUN: begin
        st_next.seq = CCR_RUN;
      end
      default: begin
        st_next.seq = CCR_INIT;
      end
    endcase
    if (!reset_n_pin) begin
      st_next.seq      = CCR_INIT; // Held while pin is low
      st_next.init_cnt = '0;
    end else if (!st_reg.rst_pin_d) begin
      st_next.seq      = CCR_INIT; // see R06
      st_next.init_cnt = '0;
    end

    // Judge a frame one cycle after its rise, once the new period is in;
    // judging at the rise itself would lag a whole frame behind
    st_next.rise_d = frame_rise;
    if (st_reg.rise_d) begin
      if (!ratio_ok) begin
        st_next.lost = 1'b1; // Unknown ratio counts as lost sync
      end else if (!st_reg.ref_valid) begin
        st_next.ref_valid = 1'b1;
      end
      if (st_reg.ref_valid && drift >= lost_lim) begin
        st_next.lost = 1'b1; // see R08 see R09
      end else if (st_reg.ref_valid && drift <= 10'(SYNC_OK_BITS) * bck_len && ratio_ok) begin
        st_next.lost = 1'b0; // see R10
      end
      st_next.ref_period = period;
    end

    // Divide down to the 256x rate
    st_next.clk_en = 1'b0;
    case (ratio_sel)
      2'h1: begin
        st_next.div_cnt = (st_reg.div_cnt == 2'h2) ? 2'h0 : st_reg.div_cnt + 2'h1;
        st_next.clk_en  = (st_reg.div_cnt != 2'h2); // see R02
      end
      2'h2: begin
        st_next.div_cnt = {1'b0, ~st_reg.div_cnt[0]};
        st_next.clk_en  = st_reg.div_cnt[0]; // see R02
      end
      default: begin
        st_next.div_cnt = '0;
        st_next.clk_en  = 1'b1; // see R02
      end
    endcase

    // Zero run detection on bit clock rises
    if (!st_reg.cfg.zero_run_detect || !dac_data_zero) begin
      st_next.zero_cnt = '0;
      st_next.disc     = 1'b0;
    end else if (serial_bit_clock && !st_reg.bck_d) begin
      if (st_reg.zero_cnt == 17'(ZERO_RUN_LEN - 1)) begin
        st_next.disc = 1'b1; // see R23
      end else begin
        st_next.zero_cnt = st_reg.zero_cnt + 17'h00001;
      end
    end

    // Program register writes; pin mode only takes format straps
    if (!software_mode) begin
      st_next.cfg.audio_frame_format = format_pins; // see R12
    end else if (word.valid) begin
      case (word.word[SEL_HI:SEL_LO]) // see R13 see R14
        SEL_LEFT: begin
          st_next.cfg.left_gain_code = word.word[GAIN_HI:0]; // see R16
          if (word.word[COMMIT_B]) begin
            st_next.cfg.left_gain_live  = word.word[GAIN_HI:0]; // see R21
            st_next.cfg.right_gain_live = st_reg.cfg.right_gain_code;
          end
        end
        SEL_RIGHT: begin
          st_next.cfg.right_gain_code = word.word[GAIN_HI:0]; // see R17
          if (word.word[COMMIT_B]) begin
            st_next.cfg.left_gain_live  = st_reg.cfg.left_gain_code; // see R21
            st_next.cfg.right_gain_live = word.word[GAIN_HI:0];
          end
        end
        SEL_MODE: begin
          st_next.cfg.adc_sleep                 = word.word[SLEEP_B]; // see R18
          st_next.cfg.hpf_skip                  = word.word[HPF_B];
          st_next.cfg.common_attenuation_select = word.word[ATC_B];
          st_next.cfg.zero_run_detect           = word.word[ZRD_B];
          st_next.cfg.dac_analog_hold_bpz       = word.word[HOLD_B];
          st_next.cfg.deemphasis_select         = word.word[DEM_HI:DEM_LO];
          st_next.cfg.soft_silence_enable       = word.word[MUTE_B];
        end
        default: begin
          st_next.cfg.adc_dac_loopback   = word.word[LOOP_B]; // see R19
          st_next.cfg.audio_frame_format = word.word[FMT_HI:FMT_LO];
          st_next.cfg.lr_clock_polarity  = word.word[LRP_B];
        end
      endcase
    end

    // Output copies ride in state so every output leaves a flip-flop
    st_next.busy      = (st_next.seq == CCR_INIT);
    st_next.dac_bpz   = st_next.lost || st_next.cfg.dac_analog_hold_bpz; // see R08
    st_next.adc_bpz   = st_next.lost || st_next.cfg.adc_sleep; // see R09
    st_next.right_out = st_next.cfg.common_attenuation_select ? st_next.cfg.left_gain_live
                                                              : st_next.cfg.right_gain_live;
  end

  // Register the state; defaults give 0 dB gain and all features off
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg                         <= '0;
      st_reg.seq                     <= CCR_INIT; // see R04
      st_reg.rst_pin_d               <= 1'b1;
      st_reg.busy                    <= 1'b1;
      st_reg.right_out               <= GAIN_RST;
      st_reg.cfg.left_gain_code      <= GAIN_RST; // see R20 see R22
      st_reg.cfg.right_gain_code     <= GAIN_RST;
      st_reg.cfg.left_gain_live      <= GAIN_RST;
      st_reg.cfg.right_gain_live     <= GAIN_RST;
      st_reg.cfg.audio_frame_format  <= FMT_RST;
      st_reg.cfg.deemphasis_select   <= DEM_RST;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from state; right gain carries the folded copy
  always_comb begin
    cfg                 = st_reg.cfg;
    cfg.right_gain_live = st_reg.right_out; // see R24
  end
  assign sysclk_pin_out = st_reg.sysclk_out;
  assign sysclk_pin_oe  = st_reg.sysclk_oe;
  assign core_clk_en    = st_reg.clk_en;
  assign init_busy      = st_reg.busy;
  assign sync_lost      = st_reg.lost;
  assign dac_force_bpz  = st_reg.dac_bpz; // see R08
  assign adc_force_bpz  = st_reg.adc_bpz; // see R09
  assign dac_disconnect = st_reg.disc;
  assign ratio_code     = ratio_sel;

  // Initialization stays busy for at least 8 cycles after release
  sequence pin_release_s;
    $rose(reset_n_pin) && ce;
  endsequence
  init_len_a: assert property (@(posedge clk) disable iff (srst) // see R06
    pin_release_s ##1 (ce && reset_n_pin)[*8] |-> init_busy)
    else $error("init ended too early");

  commit_a: assert property (@(posedge clk) disable iff (srst) // see R21
    (ce && software_mode && word.valid && word.word[SEL_HI:SEL_LO] == SEL_LEFT
     && !word.word[COMMIT_B]) |=> $stable(st_reg.cfg.left_gain_live))
    else $error("gain applied without commit");

  bpz_hold_a: assert property (@(posedge clk) disable iff (srst) // see R08
    sync_lost |-> dac_force_bpz && adc_force_bpz)
    else $error("outputs not forced at sync loss");

  xtal_oe_a: assert property (@(posedge clk) disable iff (srst) // see R03
    (ce && crystal_in != st_reg.xtal_d) ##1 ce |=> sysclk_pin_oe)
    else $error("crystal seen but pin not driven");

  atc_fold_a: assert property (@(posedge clk) disable iff (srst) // see R24
    cfg.common_attenuation_select |-> cfg.right_gain_live == cfg.left_gain_live)
    else $error("common gain not applied to right");

  // A frame is judged once its period and the reference are both known
  sequence period_judged_s;
    ce && st_reg.rise_d && st_reg.ref_valid;
  endsequence
  sync_loss_a: assert property (@(posedge clk) disable iff (srst) // see R08
    (period_judged_s ##0 drift >= lost_lim) |=> sync_lost)
    else $error("frame drift not flagged");

endmodule : ccr_top

// ### ccr_pkg.sv
// Package: constants and carrier types for the codec clock and reset control block
package ccr_pkg;

  // Clock and reset timing
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
  localparam int unsigned RST_MIN_NS      = 40;
  localparam int unsigned RST_MIN_CYC_RAW = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_MIN_CYC     = (RST_MIN_CYC_RAW < 1) ? 1 : RST_MIN_CYC_RAW;
  localparam int unsigned INIT_CYCLES     = 1024;

  // Clock ratios measured per frame
  localparam logic [9:0] RATIO_256 = 10'h100;
  localparam logic [9:0] RATIO_384 = 10'h180;
  localparam logic [9:0] RATIO_512 = 10'h200;

  // Sync tolerance in serial bit clocks
  localparam logic [3:0] SYNC_LOSS_BITS = 4'h6;
  localparam logic [3:0] SYNC_OK_BITS   = 4'h5;

  // Zero run length in serial bit clocks
  localparam int unsigned ZERO_RUN_BITS = 65_536;

  // Control word layout
  localparam int unsigned CW_BITS   = 16;
  localparam int unsigned SEL_HI    = 10;
  localparam int unsigned SEL_LO    = 9;
  localparam int unsigned COMMIT_B  = 8;
  localparam int unsigned GAIN_HI   = 7;
  localparam int unsigned SLEEP_B   = 8;
  localparam int unsigned HPF_B     = 7;
  localparam int unsigned ATC_B     = 5;
  localparam int unsigned ZRD_B     = 4;
  localparam int unsigned HOLD_B    = 3;
  localparam int unsigned DEM_HI    = 2;
  localparam int unsigned DEM_LO    = 1;
  localparam int unsigned MUTE_B    = 0;
  localparam int unsigned LOOP_B    = 5;
  localparam int unsigned FMT_HI    = 4;
  localparam int unsigned FMT_LO    = 2;
  localparam int unsigned LRP_B     = 1;

  // Register select codes
  localparam logic [1:0] SEL_LEFT  = 2'h0;
  localparam logic [1:0] SEL_RIGHT = 2'h1;
  localparam logic [1:0] SEL_MODE  = 2'h2;
  localparam logic [1:0] SEL_FMT   = 2'h3;

  // Reset values
  localparam logic [7:0] GAIN_RST = 8'hFF;
  localparam logic [2:0] FMT_RST  = 3'h0;
  localparam logic [1:0] DEM_RST  = 2'h0;

  // Decoded program settings
  typedef struct packed {
    logic [7:0] left_gain_code;
    logic [7:0] right_gain_code;
    logic [7:0] left_gain_live;
    logic [7:0] right_gain_live;
    logic       adc_sleep;
    logic       hpf_skip;
    logic       common_attenuation_select;
    logic       zero_run_detect;
    logic       dac_analog_hold_bpz;
    logic [1:0] deemphasis_select;
    logic       soft_silence_enable;
    logic       adc_dac_loopback;
    logic [2:0] audio_frame_format;
    logic       lr_clock_polarity;
  } ccr_cfg_t;

  // Control port word carrier
  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } ccr_word_t;

  typedef enum {
    CCR_INIT,
    CCR_RUN
  } ccr_seq_t;

endpackage : ccr_pkg

// ### ccr_serial_port.sv
// Three-wire control port shift register and latch detector
module ccr_serial_port
  import ccr_pkg::*;
(
  input  wire logic             clk,        // System clock
  input  wire logic             srst,       // Synchronous reset
  input  wire logic             ce,         // Clock enable
  input  wire logic             shift_clk,  // control_shift_clock level
  input  wire logic             ser_data,   // control_serial_data level
  input  wire logic             latch_stb,  // control_latch_strobe level
  output ccr_pkg::ccr_word_t    word_out    // Word on latch rise, one cycle
);
  import ccr_pkg::*;

  typedef struct packed {
    logic        sck_d;
    logic        stb_d;
    logic [15:0] shreg;
    ccr_word_t   out;
  } ccr_sp_state_t;

  ccr_sp_state_t st_reg;
  ccr_sp_state_t st_next;

  // Shift MSB first on shift clock rise, emit on strobe rise
  always_comb begin
    st_next = st_reg;
    st_next.sck_d = shift_clk;
    st_next.stb_d = latch_stb;
    st_next.out.valid = 1'b0;
    if (shift_clk && !st_reg.sck_d) begin
      st_next.shreg = {st_reg.shreg[14:0], ser_data}; // see R25
    end
    if (latch_stb && !st_reg.stb_d) begin
      st_next.out.valid = 1'b1; // see R25
      st_next.out.word  = st_reg.shreg;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign word_out = st_reg.out;

endmodule : ccr_serial_port

// ### ccr_ratio_detect.sv
// Frame period counter that classifies the system clock ratio
module ccr_ratio_detect
  import ccr_pkg::*;
(
  input  wire logic       clk,        // System clock
  input  wire logic       srst,       // Synchronous reset
  input  wire logic       ce,         // Clock enable
  input  wire logic       frame_rise, // One cycle at frame clock rise
  output logic      [1:0] ratio_sel,  // 0:256 1:384 2:512
  output logic            ratio_ok,   // Last period matched a ratio
  output logic      [9:0] period      // Last measured period
);
  import ccr_pkg::*;

  typedef struct packed {
    logic [9:0] cnt;
    logic [9:0] period;
    logic [1:0] sel;
    logic       ok;
  } ccr_rd_state_t;

  ccr_rd_state_t st_reg;
  ccr_rd_state_t st_next;

  // Count clocks per frame and compare with the three ratios
  always_comb begin
    st_next = st_reg;
    st_next.cnt = (st_reg.cnt == 10'h3FF) ? st_reg.cnt : st_reg.cnt + 10'h001;
    if (frame_rise) begin
      st_next.cnt    = 10'h001;
      st_next.period = st_reg.cnt;
      st_next.ok     = 1'b1;
      if (st_reg.cnt == RATIO_256) begin
        st_next.sel = 2'h0; // see R26
      end else if (st_reg.cnt == RATIO_384) begin
        st_next.sel = 2'h1; // see R26
      end else if (st_reg.cnt == RATIO_512) begin
        st_next.sel = 2'h2; // see R26
      end else begin
        st_next.ok = 1'b0; // Keeps the last good ratio
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign ratio_sel = st_reg.sel;
  assign ratio_ok  = st_reg.ok;
  assign period    = st_reg.period;

endmodule : ccr_ratio_detect

// ### ccr_host_model.sv
// Host side model: control port, frame and bit clocks, reset pin
module ccr_host_model (
  input  wire logic clk,                  // System clock
  output logic      reset_n_pin,          // Reset request, active low
  output logic      sample_frame_clock,   // Frame clock
  output logic      serial_bit_clock,     // Bit clock, four clk long
  output logic      control_shift_clock,  // Control shift clock
  output logic      control_serial_data,  // Control data
  output logic      control_latch_strobe  // Control latch
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle levels at time zero
  initial begin
    reset_n_pin          = 1'b1;
    sample_frame_clock   = 1'b0;
    serial_bit_clock     = 1'b0;
    control_shift_clock  = 1'b0;
    control_serial_data  = 1'b0;
    control_latch_strobe = 1'b0;
  end

  // Each level is held two clocks, as the port's edge detect needs
  task automatic send_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk);
      control_shift_clock <= 1'b0;
      control_serial_data <= w[i];
      repeat (2) @(posedge clk);
      control_shift_clock <= 1'b1;
      @(posedge clk);
    end
    @(posedge clk);
    control_latch_strobe <= 1'b1;
    repeat (2) @(posedge clk);
    control_latch_strobe <= 1'b0;
    // Released data line shows the inverse, never a stale bit
    control_serial_data  <= ~control_serial_data;
    repeat (2) @(posedge clk);
  endtask : send_word

  // Frame clock locked to clk; bit clock only runs inside frames
  task automatic frames(input int period, input int n);
    for (int f = 0; f < n; f++) begin
      for (int c = 0; c < period; c++) begin
        @(posedge clk);
        sample_frame_clock <= (c < period / 2);
        serial_bit_clock   <= c[1];
      end
    end
  endtask : frames

  // Two clocks low is well over the minimum pulse
  task automatic pulse_reset();
    @(posedge clk);
    reset_n_pin <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n_pin <= 1'b1;
  endtask : pulse_reset
endmodule : ccr_host_model

// ### tb_top.sv
// Self-checking bench for the codec clock and reset control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ccr_pkg::*;

  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic              software_mode = 1'b1;
  logic              crystal_in = 1'b0;
  logic              dac_data_zero = 1'b0;
  logic        [2:0] format_pins = 3'h0;
  logic              reset_n_pin, sample_frame_clock, serial_bit_clock;
  logic              control_shift_clock, control_serial_data, control_latch_strobe;
  logic              sysclk_pin_out, sysclk_pin_oe, core_clk_en, init_busy;
  logic              sync_lost, dac_force_bpz, adc_force_bpz, dac_disconnect;
  logic        [1:0] ratio_code;
  ccr_cfg_t          cfg;
  logic       [31:0] lfsr_reg = 32'h0f0a_3650;
  int                bad_count = 0;
  int                tests_run = 0;
  int                reg_m[4];
  int                live_l, live_r;

  always #25 clk = ~clk;

  ccr_top #(.ZERO_RUN_LEN(16), .INIT_LEN(16)) ccr_top_i (
    .clk(clk), .srst(srst), .ce(1'b1), .software_mode(software_mode),
    .reset_n_pin(reset_n_pin), .crystal_in(crystal_in), .sysclk_pin_in(1'b0),
    .sample_frame_clock(sample_frame_clock), .serial_bit_clock(serial_bit_clock),
    .dac_data_zero(dac_data_zero), .control_shift_clock(control_shift_clock),
    .control_serial_data(control_serial_data),
    .control_latch_strobe(control_latch_strobe), .format_pins(format_pins),
    .sysclk_pin_out(sysclk_pin_out), .sysclk_pin_oe(sysclk_pin_oe),
    .core_clk_en(core_clk_en), .init_busy(init_busy), .sync_lost(sync_lost),
    .dac_force_bpz(dac_force_bpz), .adc_force_bpz(adc_force_bpz),
    .dac_disconnect(dac_disconnect), .ratio_code(ratio_code), .cfg(cfg));

  ccr_host_model ccr_host_model_i (
    .clk(clk), .reset_n_pin(reset_n_pin), .sample_frame_clock(sample_frame_clock),
    .serial_bit_clock(serial_bit_clock), .control_shift_clock(control_shift_clock),
    .control_serial_data(control_serial_data),
    .control_latch_strobe(control_latch_strobe));

  // Fixed-seed pseudo random source
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic chk(input string nm, input int exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp[15:0]) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp[15:0], got);
    end
  endtask : chk

  task automatic end_test(input string nm);
    $display("test %s done, mismatches so far %0d", nm, bad_count);
  endtask : end_test

  // Every field of the settings against the bench model
  task automatic check_cfg();
    chk("left_code", reg_m[0] & 255, cfg.left_gain_code);
    chk("right_code", reg_m[1] & 255, cfg.right_gain_code);
    chk("left_live", live_l, cfg.left_gain_live);
    chk("right_live", reg_m[2][5] ? live_l : live_r, cfg.right_gain_live);
    chk("sleep", reg_m[2][8], cfg.adc_sleep);
    chk("hpf", reg_m[2][7], cfg.hpf_skip);
    chk("atc", reg_m[2][5], cfg.common_attenuation_select);
    chk("zrd", reg_m[2][4], cfg.zero_run_detect);
    chk("hold", reg_m[2][3], cfg.dac_analog_hold_bpz);
    chk("dem", (reg_m[2] >> 1) & 3, cfg.deemphasis_select);
    chk("mute", reg_m[2][0], cfg.soft_silence_enable);
    chk("loop", reg_m[3][5], cfg.adc_dac_loopback);
    chk("fmt", (reg_m[3] >> 2) & 7, cfg.audio_frame_format);
    chk("lrp", reg_m[3][1], cfg.lr_clock_polarity);
    chk("dac_bpz", reg_m[2][3], dac_force_bpz);
    chk("adc_bpz", reg_m[2][8], adc_force_bpz);
  endtask : check_cfg

  // Reserved bits always zero; select in bits 10:9
  task automatic wr(input int sel, input int val);
    ccr_host_model_i.send_word({5'h00, sel[1:0], val[8:0]});
    reg_m[sel] = val & 'h1FF;
    if (sel < 2 && val[8]) begin
      live_l = reg_m[0] & 255;
      live_r = reg_m[1] & 255;
    end
    repeat (2) @(posedge clk);
    check_cfg();
  endtask : wr

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // Whole run is near 9.5k clocks; this leaves ample margin
  initial begin
    #3_000_000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    int p[3];
    p = '{384, 512, 256};
    reg_m = '{255, 255, 0, 0};
    live_l = 255;
    live_r = 255;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1 chk("init_busy", 1, init_busy);
    repeat (30) @(posedge clk);
    chk("init_busy", 0, init_busy);
    check_cfg();
    ccr_host_model_i.pulse_reset();
    repeat (14) @(posedge clk);
    chk("init_busy", 1, init_busy);
    repeat (8) @(posedge clk);
    chk("init_busy", 0, init_busy);
    end_test("reset");
    for (int i = 0; i < 3; i++) begin
      ccr_host_model_i.frames(p[i], 4);
      chk("ratio_code", (i + 1) % 3, ratio_code);
    end
    end_test("ratio");
    ccr_host_model_i.frames(256, 3);
    chk("sync_lost", 0, sync_lost);
    chk("dac_bpz", 0, dac_force_bpz);
    chk("clk_en", 1, core_clk_en);
    // Frame drifts by 64 clocks, 16 bit clocks
    ccr_host_model_i.frames(320, 1);
    ccr_host_model_i.frames(256, 1);
    chk("sync_lost", 1, sync_lost);
    chk("dac_bpz", 1, dac_force_bpz);
    chk("adc_bpz", 1, adc_force_bpz);
    ccr_host_model_i.frames(256, 3);
    chk("sync_lost", 0, sync_lost);
    chk("adc_bpz", 0, adc_force_bpz);
    end_test("sync");
    for (int i = 0; i < 100; i++) begin
      @(posedge clk);
      crystal_in <= ~crystal_in;
    end
    chk("sysclk_oe", 1, sysclk_pin_oe);
    crystal_in <= 1'b0;
    #1 chk("sysclk_out", 1, sysclk_pin_out);
    repeat (100) @(posedge clk);
    chk("sysclk_oe", 0, sysclk_pin_oe);
    end_test("crystal");
    for (int k = 0; k < 6; k++) begin
      lfsr_reg = lfsr_next(lfsr_reg);
      wr(0, lfsr_reg[8:0]);
      wr(1, lfsr_reg[17:9]);
      wr(2, lfsr_reg[26:18] & 'h1BF);
      wr(3, {lfsr_reg[31:27], 1'b0});
    end
    wr(0, 'h100);
    wr(1, 'h1FF);
    end_test("registers");
    wr(2, 'h010);
    dac_data_zero <= 1'b1;
    ccr_host_model_i.frames(256, 1);
    chk("disconnect", 1, dac_disconnect);
    dac_data_zero <= 1'b0;
    ccr_host_model_i.frames(256, 1);
    chk("disconnect", 0, dac_disconnect);
    end_test("zero_run");
    software_mode <= 1'b0;
    format_pins <= lfsr_reg[2:0];
    repeat (4) @(posedge clk);
    chk("pin_fmt", lfsr_reg[2:0], cfg.audio_frame_format);
    ccr_host_model_i.send_word(16'h0055);
    repeat (4) @(posedge clk);
    chk("left_code", reg_m[0] & 255, cfg.left_gain_code);
    end_test("pin_mode");
    report_and_stop();
  end
endmodule : tb_top
